// ===== src/process_pid_regulator.sv
// Process PID regulator: setting versus feedback to frequency correction
//
// Local design decisions: the strobed register port and the register addresses.
`include "process_pid_regulator_regs.svh"
module process_pid_regulator #(
  parameter int unsigned TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire pid_pkg::word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pid_pkg::word_t reg_rdata,
  input wire pid_pkg::word_t setting_pct,
  input wire pid_pkg::word_t feedback_pct,
  input wire logic drive_run,
  input wire pid_pkg::di_t di_pins,
  output pid_pkg::out_t freq_correction,
  output logic output_tick,
  output pid_pkg::word_t setting_display,
  output pid_pkg::word_t feedback_display,
  output logic feedback_loss_fault
);
  import pid_pkg::*;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam acc_t FULL = acc_t'(`PCT_FULL);
  localparam acc_t FULL_Q = acc_t'(`PCT_FULL) <<< `Q_FRAC;
  localparam acc_t TPC = acc_t'(`CS_US / `TICK_US);
  localparam acc_t TPD = acc_t'(`DS_US / `TICK_US);
  localparam acc_t MS_PER_TICK = acc_t'(`TICK_US / `MS_US);
  localparam acc_t GAIN_ONE = acc_t'(`GAIN_ONE);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam word_t [`NREG_RW-1:0] REG_RST = {
    `RST_MAX_FREQ, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_STEP, `RST_STEP, `RST_ZERO, `RST_ZERO, `RST_SW_HI,
    `RST_SW_LO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_DLIMIT, `RST_ZERO, `RST_REV_CUT, `RST_ZERO, `RST_ITIME,
    `RST_GAIN, `RST_ZERO, `RST_ITIME, `RST_GAIN, `RST_DISP_RANGE,
    `RST_ZERO};
  localparam state_t RST_STATE = '{regs: REG_RST, default: '0};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic acc_t uw(input word_t w);
    uw = acc_t'({16'h0000, w});
  endfunction : uw

  function automatic acc_t sw(input word_t w);
    sw = acc_t'({{16{w[15]}}, w});
  endfunction : sw

  // Saturate instead of wrapping
  function automatic acc_t sat(input acc_t v, input acc_t lo, input acc_t hi);
    if (v < lo) begin
      sat = lo;
    end else if (v > hi) begin
      sat = hi;
    end else begin
      sat = v;
    end
  endfunction : sat

  // Blend of two constants, weight of set 2 out of full scale
  function automatic acc_t mix(input acc_t a, input acc_t b, input acc_t w);
    mix = a + ((b - a) * w) / FULL;
  endfunction : mix

  // First-order low-pass step; zero time constant passes the input
  function automatic acc_t lpf(input acc_t y, input acc_t x, input acc_t tau);
    if (tau == 0) begin
      lpf = x;
    end else begin
      lpf = y + (x - y) / (TPC * tau);
    end
  endfunction : lpf

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t st_ff;
  state_t nxt_st;
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] dq;
  logic act;
  logic dir;
  logic pause;
  logic dead;
  logic at_lim;
  acc_t tgt;
  acc_t step;
  acc_t sp;
  acc_t fb;
  acc_t e;
  acc_t ae;
  acc_t w;
  acc_t lo;
  acc_t hi;
  acc_t kp;
  acc_t ti;
  acc_t td;
  acc_t p;
  acc_t d;
  acc_t u;
  acc_t cut;
  acc_t nout;
  acc_t mf;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    s1 = st_ff.di_sync[1];
    s2 = st_ff.di_sync[2];
    dq = st_ff.di_q;
    act = 1'b0;
    dir = 1'b0;
    pause = 1'b0;
    dead = 1'b0;
    at_lim = 1'b0;
    tgt = '0;
    step = '0;
    sp = '0;
    fb = '0;
    e = '0;
    ae = '0;
    w = '0;
    lo = '0;
    hi = '0;
    kp = '0;
    ti = '0;
    td = '0;
    p = '0;
    d = '0;
    u = '0;
    cut = '0;
    nout = '0;
    mf = '0;
    nxt_st.tick = 1'b0;
    nxt_st.rdata = '0;
    nxt_st.run_prev = drive_run;

    // Three-stage pin sync; a bit changes once stages two and three agree
    nxt_st.di_sync[0] = di_pins;
    nxt_st.di_sync[1] = st_ff.di_sync[0];
    nxt_st.di_sync[2] = st_ff.di_sync[1];
    for (int i = 0; i < 3; i++) begin
      if (s1[i] == s2[i]) begin
        dq[i] = s2[i];
      end
    end
    nxt_st.di_q = dq;

    // Register writes; fault clear comes first so a new fault wins
    if (reg_wr) begin
      if (reg_addr < `ADDR_W'(`NREG_RW)) begin
        nxt_st.regs[reg_addr] = reg_wdata;
      end
      if (reg_addr == `ADDR_W'(`REG_STATUS) && reg_wdata[`ST_FAULT]) begin
        nxt_st.fault = 1'b0;
      end
    end

    // Register reads; data stands in the following cycle only
    if (reg_rd) begin
      if (reg_addr < `ADDR_W'(`NREG_RW)) begin
        nxt_st.rdata = st_ff.regs[reg_addr];
      end else begin
        case (reg_addr)
          `ADDR_W'(`REG_SET_DISP): nxt_st.rdata = st_ff.set_disp;
          `ADDR_W'(`REG_FB_DISP): nxt_st.rdata = st_ff.fb_disp;
          `ADDR_W'(`REG_STATUS): begin
            nxt_st.rdata[`ST_FAULT] = st_ff.fault;
            nxt_st.rdata[`ST_HOLD] = (st_ff.hold_cnt != 0);
            nxt_st.rdata[`ST_ACTIVE] = drive_run | st_ff.regs[`REG_RUN_STOP][0];
          end
          `ADDR_W'(`REG_OUTPUT): nxt_st.rdata = st_ff.out_q[15:0];
          default: nxt_st.rdata = '0;
        endcase
      end
    end

    // A rising drive_run edge loads the hold time in ticks; a start from the run register bit loads none
    act = drive_run | st_ff.regs[`REG_RUN_STOP][0];
    if (drive_run && !st_ff.run_prev) begin
      nxt_st.hold_cnt = 32'(uw(st_ff.regs[`REG_HOLD_TIME]) * TPC);
    end

    // 2 ms output period
    if (st_ff.tick_cnt >= TICK_LAST) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
    end

    if (st_ff.tick) begin
      // Setting ramp, linear over the configured full-scale time
      tgt = sat(uw(setting_pct), '0, FULL) <<< `Q_FRAC;
      if (st_ff.regs[`REG_RAMP] == 0) begin
        nxt_st.set_q16 = tgt;
      end else begin
        step = FULL_Q / (TPC * uw(st_ff.regs[`REG_RAMP]));
        if (step == 0) begin
          step = acc_t'(1);
        end
        if (st_ff.set_q16 < tgt) begin
          nxt_st.set_q16 = sat(st_ff.set_q16 + step, '0, tgt);
        end else begin
          nxt_st.set_q16 = sat(st_ff.set_q16 - step, tgt, FULL_Q);
        end
      end
      sp = nxt_st.set_q16 >>> `Q_FRAC;

      // Feedback filter
      nxt_st.fb_q16 = lpf(st_ff.fb_q16, sat(uw(feedback_pct), '0, FULL) <<< `Q_FRAC,
                          uw(st_ff.regs[`REG_FB_FILT]));
      fb = nxt_st.fb_q16 >>> `Q_FRAC;

      // Deviation with direction and its inversion input
      dir = st_ff.regs[`REG_DIR][0] ^ st_ff.di_q.reverse;
      e = dir ? fb - sp : sp - fb;
      ae = (e < 0) ? -e : e;
      dead = ae < uw(st_ff.regs[`REG_DEADBAND]);

      // Weight of set 2
      lo = uw(st_ff.regs[`REG_SW_LO]);
      hi = uw(st_ff.regs[`REG_SW_HI]);
      case (st_ff.regs[`REG_SW_MODE][1:0])
        2'h1: w = st_ff.di_q.gain_sw ? FULL : '0;
        2'h2: begin
          if (ae <= lo) begin
            w = '0;
          end else if (ae >= hi) begin
            w = FULL;
          end else begin
            w = ((ae - lo) * FULL) / (hi - lo);
          end
        end
        default: w = '0;
      endcase
      kp = mix(uw(st_ff.regs[`REG_GAIN1]), uw(st_ff.regs[`REG_GAIN2]), w);
      ti = mix(uw(st_ff.regs[`REG_ITIME1]), uw(st_ff.regs[`REG_ITIME2]), w);
      td = mix(uw(st_ff.regs[`REG_DTIME1]), uw(st_ff.regs[`REG_DTIME2]), w);
      if (ti < 1) begin
        ti = acc_t'(1);
      end

      // Proportional and differential terms
      p = (kp * e) / GAIN_ONE;
      d = ((dir ? fb - st_ff.fb_prev : st_ff.fb_prev - fb) * td) / MS_PER_TICK;
      d = sat(d, -uw(st_ff.regs[`REG_DLIMIT]), uw(st_ff.regs[`REG_DLIMIT]));
      nxt_st.fb_prev = fb;

      // Reverse limit in percent of maximum frequency
      mf = uw(st_ff.regs[`REG_MAX_FREQ]);
      cut = (mf == 0) ? '0 : sat((uw(st_ff.regs[`REG_REV_CUT]) * FULL) / mf, '0, FULL);
      at_lim = (st_ff.out_raw >= FULL) || (st_ff.out_raw <= -cut);

      // Integral with pause and anti-windup
      pause = (st_ff.regs[`REG_INTEG_PROP][3:0] != 0) && st_ff.di_q.integ_pause;
      pause = pause || ((st_ff.regs[`REG_INTEG_PROP][7:4] != 0) && at_lim);
      if (!pause && !dead) begin
        nxt_st.integ = sat(st_ff.integ + (e <<< `Q_FRAC) / (TPC * ti),
                           -FULL_Q, FULL_Q);
      end

      // Sum, reverse cut-off, then per-period step limit
      u = sat(p + (nxt_st.integ >>> `Q_FRAC) + d, -FULL, FULL);
      u = sat(u, -cut, FULL);
      nout = st_ff.out_raw + sat(u - st_ff.out_raw,
                                 -uw(st_ff.regs[`REG_REV_STEP]),
                                 uw(st_ff.regs[`REG_FWD_STEP]));
      if (dead) begin
        nout = st_ff.out_raw;
      end

      // Start-up hold and stopped behaviour take precedence
      if (!act) begin
        nout = '0;
        nxt_st.integ = '0;
        nxt_st.hold_cnt = '0;
      end else if (st_ff.hold_cnt != 0) begin
        nout = sat(sw(st_ff.regs[`REG_INIT_VAL]), -FULL, FULL);
        nxt_st.integ = nout <<< `Q_FRAC;
        nxt_st.hold_cnt = st_ff.hold_cnt - 32'h0000_0001;
      end
      nxt_st.out_raw = nout;

      // Output filter
      nxt_st.out_q16 = lpf(st_ff.out_q16, nout <<< `Q_FRAC,
                           uw(st_ff.regs[`REG_OUT_FILT]));
      nxt_st.out_q = out_t'(nxt_st.out_q16 >>> `Q_FRAC);

      // Feedback loss: fault once the low time exceeds the limit
      if (st_ff.regs[`REG_LOSS_THR] != 0 && fb < uw(st_ff.regs[`REG_LOSS_THR])) begin
        if (st_ff.loss_cnt >= 32'(uw(st_ff.regs[`REG_LOSS_TIME]) * TPD)) begin
          nxt_st.fault = 1'b1;
        end else begin
          nxt_st.loss_cnt = st_ff.loss_cnt + 32'h0000_0001;
        end
      end else begin
        nxt_st.loss_cnt = '0;
      end

      // Display values scaled to the display range
      nxt_st.set_disp = word_t'((sp * uw(st_ff.regs[`REG_DISP_RANGE])) / FULL);
      nxt_st.fb_disp = word_t'((fb * uw(st_ff.regs[`REG_DISP_RANGE])) / FULL);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_ff.rdata;
  assign freq_correction = st_ff.out_q;
  assign output_tick = st_ff.tick;
  assign setting_display = st_ff.set_disp;
  assign feedback_display = st_ff.fb_disp;
  assign feedback_loss_fault = st_ff.fault;

endmodule : process_pid_regulator

// ===== src/process_pid_regulator_regs.svh
// Register indices, reset values and timing figures of the process regulator
`ifndef PROCESS_PID_REGULATOR_REGS_SVH
`define PROCESS_PID_REGULATOR_REGS_SVH
// ----------------------------------------------------------------
// Bus and register indices
// ----------------------------------------------------------------
`define ADDR_W 5
`define NREG_RW 26
`define REG_DIR 0
`define REG_DISP_RANGE 1
`define REG_GAIN1 2
`define REG_ITIME1 3
`define REG_DTIME1 4
`define REG_GAIN2 5
`define REG_ITIME2 6
`define REG_DTIME2 7
`define REG_REV_CUT 8
`define REG_DEADBAND 9
`define REG_DLIMIT 10
`define REG_RAMP 11
`define REG_FB_FILT 12
`define REG_OUT_FILT 13
`define REG_SW_MODE 14
`define REG_SW_LO 15
`define REG_SW_HI 16
`define REG_INIT_VAL 17
`define REG_HOLD_TIME 18
`define REG_FWD_STEP 19
`define REG_REV_STEP 20
`define REG_INTEG_PROP 21
`define REG_LOSS_THR 22
`define REG_LOSS_TIME 23
`define REG_RUN_STOP 24
`define REG_MAX_FREQ 25
`define REG_SET_DISP 26
`define REG_FB_DISP 27
`define REG_STATUS 28
`define REG_OUTPUT 29
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ST_FAULT 0
`define ST_HOLD 1
`define ST_ACTIVE 2
`define RST_ZERO 16'h0000
`define RST_DISP_RANGE 16'h03E8
`define RST_GAIN 16'h00C8
`define RST_ITIME 16'h00C8
`define RST_REV_CUT 16'h00C8
`define RST_DLIMIT 16'h000A
`define RST_SW_LO 16'h07D0
`define RST_SW_HI 16'h1F40
`define RST_STEP 16'h0064
`define RST_MAX_FREQ 16'h1388
// ----------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------
`define PCT_FULL 10000
`define GAIN_ONE 1000
`define Q_FRAC 16
`define CLK_MHZ 125
`define TICK_US 2000
`define CS_US 10000
`define DS_US 100000
`define MS_US 1000
`endif

// ===== src/pid_pkg.sv
// Types shared by the process regulator and its bench
package pid_pkg;
  `include "process_pid_regulator_regs.svh"
  typedef logic [15:0] word_t;
  typedef logic signed [31:0] acc_t;
  typedef logic signed [16:0] out_t;
  // Digital input functions: reverse, set switch, integral pause
  typedef struct packed {
    logic reverse;
    logic gain_sw;
    logic integ_pause;
  } di_t;
  typedef struct packed {
    word_t [`NREG_RW-1:0] regs;
    di_t [2:0] di_sync;
    di_t di_q;
    logic [31:0] tick_cnt;
    acc_t set_q16;
    acc_t fb_q16;
    acc_t fb_prev;
    acc_t integ;
    acc_t out_raw;
    acc_t out_q16;
    logic [31:0] hold_cnt;
    logic [31:0] loss_cnt;
    logic run_prev;
    logic fault;
    logic tick;
    word_t rdata;
    out_t out_q;
    word_t set_disp;
    word_t fb_disp;
  } state_t;
endpackage : pid_pkg

// ===== verification/pid_monitor.sv
// Port checker for the process regulator, bound to its top module
`include "process_pid_regulator_regs.svh"
module pid_monitor #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire pid_pkg::word_t reg_wdata,
  input wire logic reg_wr,
  input wire pid_pkg::out_t freq_correction,
  input wire logic output_tick,
  input wire pid_pkg::word_t setting_display,
  input wire logic feedback_loss_fault
);
  import pid_pkg::*;
  // Limitation: assumes default cut-off and maximum frequency (4.00 percent)
  localparam int CUT = 400;
  logic [31:0] gap_ff;
  logic seen_ff;
  // Cycles since the last tick; the first tick after reset is not judged
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      gap_ff <= 32'h0;
      seen_ff <= 1'b0;
    end else if (output_tick) begin
      gap_ff <= 32'h1;
      seen_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + 32'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  tick_period_a: assert property (output_tick && seen_ff |-> gap_ff == TICK_CYCLES)
    else $error("tick spacing wrong");
  tick_single_a: assert property (output_tick |=> !output_tick)
    else $error("tick longer than one cycle");
  out_on_tick_a: assert property ($changed(freq_correction) |-> $past(output_tick))
    else $error("output moved between ticks");
  disp_on_tick_a: assert property ($changed(setting_display) |-> $past(output_tick))
    else $error("display moved between ticks");
  rev_cutoff_a: assert property (freq_correction >= -CUT)
    else $error("reverse output beyond cut-off");
  full_scale_a: assert property (freq_correction <= 10000)
    else $error("output above full scale");
  fault_sticky_a: assert property (feedback_loss_fault
    && !(reg_wr && reg_addr == 5'h1C && reg_wdata[0]) |=> feedback_loss_fault)
    else $error("fault dropped without clear");
  fault_on_tick_a: assert property ($rose(feedback_loss_fault) |-> $past(output_tick))
    else $error("fault rose off tick");
endmodule : pid_monitor

bind process_pid_regulator pid_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .freq_correction(freq_correction),
  .output_tick(output_tick),
  .setting_display(setting_display),
  .feedback_loss_fault(feedback_loss_fault)
);

// ===== verification/process_plant.sv
// Process model: fixed feedback, or feedback that follows the correction
module process_plant (
  input wire logic ref_clk,
  input wire logic output_tick,
  input wire pid_pkg::out_t freq_correction,
  input wire pid_pkg::word_t fb_fixed,
  input wire logic follow,
  output pid_pkg::word_t feedback_pct
);
  import pid_pkg::*;
  int nxt_fb;
  // Feedback drifts by one eighth of the correction each period
  assign nxt_fb = int'(feedback_pct) + int'(freq_correction) / 8;
  // Feedback stays within 0..100 percent in follow mode, like a real transmitter; fixed feedback passes unclamped
  always_ff @(posedge ref_clk) begin
    if (!follow) begin
      feedback_pct <= fb_fixed;
    end else if (output_tick) begin
      feedback_pct <= word_t'((nxt_fb < 0) ? 0 : (nxt_fb > 10000) ? 10000 : nxt_fb);
    end
  end
endmodule : process_plant

// ===== verification/testbench.sv
// Self-checking bench for the process regulator
`include "process_pid_regulator_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pid_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic ref_clk, resetn, reg_wr, reg_rd, drive_run, follow, output_tick, feedback_loss_fault;
  logic [`ADDR_W-1:0] reg_addr;
  word_t reg_wdata, reg_rdata, setting_pct, feedback_pct, fb_fixed, rv;
  word_t setting_display, feedback_display;
  di_t di_pins;
  out_t freq_correction, prev;
  int err_total, num_checks, d;
  int rst_adr [16] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 15, 16, 19, 20, 25, 30};
  word_t rst_val [16] = '{16'h0000, 16'h03E8, 16'h00C8, 16'h00C8, 16'h0000, 16'h00C8,
    16'h00C8, 16'h00C8, 16'h0000, 16'h000A, 16'h07D0, 16'h1F40, 16'h0064, 16'h0064,
    16'h1388, 16'h0000};
  process_pid_regulator #(.TICK_CYCLES(20)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .setting_pct(setting_pct), .feedback_pct(feedback_pct),
    .drive_run(drive_run), .di_pins(di_pins), .freq_correction(freq_correction),
    .output_tick(output_tick), .setting_display(setting_display),
    .feedback_display(feedback_display), .feedback_loss_fault(feedback_loss_fault));
  process_plant plant (.ref_clk(ref_clk), .output_tick(output_tick),
    .freq_correction(freq_correction), .fb_fixed(fb_fixed), .follow(follow),
    .feedback_pct(feedback_pct));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input int a, input word_t v);
    @(posedge ref_clk);
    reg_addr <= 5'(a);
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input int a);
    @(posedge ref_clk);
    reg_addr <= 5'(a);
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  // Bounded wait for each tick, then let the update edge land
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (output_tick !== 1'b1 && k < 100) begin
        @(posedge ref_clk);
        #1 k++;
      end
      if (k == 100) err_total++;
      @(posedge ref_clk);
      #1;
    end
  endtask : ticks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // Watchdog: the tests need about 220 ticks of 20 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {resetn, reg_wr, reg_rd, drive_run, follow} = 5'h0;
    reg_addr = '0;
    reg_wdata = '0;
    setting_pct = 16'h1770;
    fb_fixed = 16'h0FA0;
    di_pins = '0;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rst_adr[i]) begin
      rd(rst_adr[i]);
      chk(32'(rv), 32'(rst_val[i]));
    end
    $display("test reset values done");
    // Direction from register and input, each combination
    for (int c = 0; c < 4; c++) begin
      wr(0, word_t'(c & 1));
      di_pins.reverse <= c[1];
      drive_run <= 1'b1;
      prev = '0;
      repeat (8) begin
        ticks(1);
        d = int'(freq_correction) - int'(prev);
        chk({31'h0, d <= 100 && d >= -100}, 32'h1);
        prev = freq_correction;
      end
      if (c == 1 || c == 2) chk(32'(freq_correction), -32'sd400);
      else chk({31'h0, freq_correction > 0}, 32'h1);
      drive_run <= 1'b0;
      ticks(2);
      chk(32'(freq_correction), 32'h0);
    end
    di_pins.reverse <= 1'b0;
    wr(0, 16'h0000);
    $display("test direction done");
    drive_run <= 1'b1;
    ticks(2);
    chk(32'(setting_display), 32'h258);
    wr(1, 16'h07D0);
    setting_pct <= 16'h2710;
    ticks(2);
    chk(32'(setting_display), 32'h7D0);
    chk(32'(feedback_display), 32'h320);
    drive_run <= 1'b0;
    setting_pct <= 16'h1770;
    wr(1, 16'h03E8);
    wr(9, 16'h09C4);
    // Let one stopped period clear the output before the dead band holds it
    ticks(1);
    drive_run <= 1'b1;
    ticks(6);
    chk(32'(freq_correction), 32'h0);
    drive_run <= 1'b0;
    wr(9, 16'h0000);
    $display("test display and dead band done");
    // Start-up hold of ten ticks at the initial value
    wr(17, 16'h01F4);
    wr(18, 16'h0002);
    drive_run <= 1'b1;
    ticks(5);
    chk(32'(freq_correction), 32'h1F4);
    rd(28);
    chk(32'(rv), 32'h6);
    ticks(8);
    rd(28);
    chk(32'(rv), 32'h4);
    drive_run <= 1'b0;
    wr(17, 16'h0000);
    wr(18, 16'h0000);
    $display("test start-up done");
    // Feedback loss over fifty ticks, clear, then disabled detection
    wr(22, 16'h03E8);
    wr(23, 16'h0001);
    fb_fixed <= 16'h01F4;
    drive_run <= 1'b1;
    ticks(45);
    chk({31'h0, feedback_loss_fault}, 32'h0);
    ticks(10);
    chk({31'h0, feedback_loss_fault}, 32'h1);
    fb_fixed <= 16'h0FA0;
    wr(28, 16'h0001);
    ticks(1);
    chk({31'h0, feedback_loss_fault}, 32'h0);
    wr(22, 16'h0000);
    fb_fixed <= 16'h0000;
    ticks(60);
    chk({31'h0, feedback_loss_fault}, 32'h0);
    drive_run <= 1'b0;
    $display("test feedback loss done");
    // Setting ramp: 0.01 s full scale moves the setting 20 percent per period
    wr(11, 16'h0001);
    setting_pct <= 16'h2710;
    ticks(1);
    chk(32'(setting_display), 32'h320);
    ticks(1);
    chk(32'(setting_display), 32'h3E8);
    setting_pct <= 16'h1770;
    ticks(2);
    chk(32'(setting_display), 32'h258);
    wr(11, 16'h0000);
    $display("test setting ramp done");
    // Closed loop: feedback is pulled up toward the setting
    fb_fixed <= 16'h0FA0;
    ticks(1);
    follow <= 1'b1;
    drive_run <= 1'b1;
    ticks(30);
    chk({31'h0, feedback_pct > 16'h0FA0}, 32'h1);
    $display("test closed loop done");
    end_of_test();
  end
endmodule : testbench
